// [rtl/vgra_pkg.sv]
// Constants, carriers and states of the version and EEPROM byte access block.
// Assumes a 32-bit APB master and a same-clock serial EEPROM byte engine.
package vgra_pkg;
    // ****************************************************************
    // Register map and fields.
    // ****************************************************************
    localparam logic [11:0] VGRA_OFS_VERSION = 12'h000; // Version register.
    localparam logic [11:0] VGRA_OFS_ACCESS  = 12'h004; // EEPROM byte access.
    localparam int          VGRA_BIT_PRESENT = 24;      // EEPROM present flag.
    localparam int          VGRA_BIT_ARST    = 31;      // Address reset bit.
    localparam int          VGRA_BIT_RSTART  = 25;      // Read start bit.
    localparam logic [7:0]  VGRA_VER_MAJOR   = 8'h01;   // Major version.
    localparam logic [7:0]  VGRA_VER_MINOR   = 8'h10;   // Minor version.
    localparam logic [7:0]  VGRA_MINI_PTR    = 8'h20;   // Mini-ROM start offset.
    localparam logic [7:0]  VGRA_MINI_OFS    = 8'h06;   // Byte holding mini-ROM flag.
    localparam int          VGRA_MINI_BIT    = 5;       // Mini-ROM flag bit.
    localparam logic [7:0]  VGRA_BIB_BYTES   = 8'h14;   // Bytes loaded after reset.
    localparam logic [7:0]  VGRA_ADDR_RST    = 8'h00;   // EEPROM address after reset.
    localparam logic [7:0]  VGRA_DATA_RST    = 8'h00;   // Read data after reset.
    localparam logic [31:0] VGRA_WORD_RST    = 32'h0000_0000; // Read bus after reset.

    // ****************************************************************
    // Carriers and states.
    // ****************************************************************
    typedef struct packed {
        logic       ack;  // One-cycle pulse: the requested byte is ready.
        logic [7:0] data; // Byte read from the EEPROM.
    } vgra_ee_rsp_t;

    typedef struct packed {
        logic       valid; // One-cycle pulse per loaded byte.
        logic [7:0] index; // Byte offset inside the bus information block.
        logic [7:0] data;  // Loaded byte.
    } vgra_bib_t;

    typedef enum logic [2:0] {
        VGRA_ST_IDLE = 3'h1, // Waiting for work.
        VGRA_ST_BOOT = 3'h2, // Loading the bus information block.
        VGRA_ST_READ = 3'h4  // Serving one software byte read.
    } vgra_state_t;
endpackage : vgra_pkg

// [rtl/vgra_core.sv]
// Version register and EEPROM byte access register behind an APB slave.
// Assumes a byte engine on the same clock that answers each request with ack.
//
// Summary of operation
// R1: Version reserved bits read as zero.
// R2: Bit 24 shows EEPROM detected.
// R3: Present EEPROM loads bus info after reset.
// R4: Major version reads one.
// R5: Minor version reads hex ten.
// R6: Software uses access register only if present.
// R7: Address reset zeroes address, then self-clears.
// R8: Address reset leaves read data unchanged.
// R9: Read start reads byte at current address.
// R10: Read start self-clears when read finishes.
// R11: Read byte appears in read data field.
// R12: Access register unused bits read zero.
// R13: Mini-ROM pointer shows hex twenty when flagged.
// R14: Software polls read start before using data.
// R15: Read-only writes ignored; zero writes cancel nothing.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module vgra_core
    import vgra_pkg::*;
#(
    parameter logic [7:0] BIB_BYTES = VGRA_BIB_BYTES // Bytes loaded after reset.
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic         i_psel,
    input  wire logic         i_penable,
    input  wire logic         i_pwrite,
    input  wire logic [11:0]  i_paddr,
    input  wire logic [31:0]  i_pwdata,
    input  wire logic [3:0]   i_pstrb,
    output logic [31:0]       o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    input  wire logic         i_ee_present,
    output logic              o_ee_req,
    output logic [7:0]        o_ee_addr,
    input  wire vgra_ee_rsp_t i_ee_rsp,
    output vgra_bib_t         o_bib,
    output logic              o_boot_done
);
    // ****************************************************************
    // State.
    // ****************************************************************
    vgra_state_t state_ff;   // Sequencer state.
    vgra_state_t nxt_state;
    logic [7:0]  addr_ff;    // Internal EEPROM byte address.
    logic [7:0]  nxt_addr;
    logic [7:0]  data_ff;    // Read data field.
    logic [7:0]  nxt_data;
    logic        arst_ff;    // Address reset bit.
    logic        nxt_arst;
    logic        rstart_ff;  // Read start bit.
    logic        nxt_rstart;
    logic        mini_ff;    // Mini-ROM flag seen during the load.
    logic        nxt_mini;
    logic        present_ff; // Registered presence flag.
    logic        nxt_present;
    logic        boot_ff;    // Load still pending after reset.
    logic        nxt_boot;
    vgra_bib_t   bib_ff;     // Loaded byte output.
    vgra_bib_t   nxt_bib;
    logic [31:0] prdata_ff;  // Read data held for the access phase.
    logic [31:0] nxt_prdata;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    logic        hit_ver;    // Address selects the version register.
    logic        hit_acc;    // Address selects the access register.
    logic        wr_acc;     // Write to the control byte of the access register.
    logic        set_arst;   // Software requests an address reset.
    logic        set_rstart; // Software requests a byte read.
    logic [31:0] rd_word;    // Read multiplexer.

    // Decodes the address and forms the write strobes.
    always_comb begin
        hit_ver    = (i_paddr == VGRA_OFS_VERSION);
        hit_acc    = (i_paddr == VGRA_OFS_ACCESS);
        wr_acc     = i_psel && i_penable && i_pwrite && hit_acc && i_pstrb[3];
        set_arst   = wr_acc && i_pwdata[VGRA_BIT_ARST];   // [R15]
        set_rstart = wr_acc && i_pwdata[VGRA_BIT_RSTART]; // [R15]
    end

    // Builds the read word; every unused bit is a constant zero.
    always_comb begin
        rd_word = VGRA_WORD_RST;
        if (hit_ver) begin
            rd_word[VGRA_BIT_PRESENT] = present_ff;    // [R2]
            rd_word[23:16]            = VGRA_VER_MAJOR; // [R4]
            rd_word[7:0]              = VGRA_VER_MINOR; // [R5] [R1]
        end else if (hit_acc) begin
            rd_word[VGRA_BIT_ARST]   = arst_ff;
            rd_word[VGRA_BIT_RSTART] = rstart_ff;
            rd_word[23:16]           = data_ff;                          // [R11]
            rd_word[7:0]             = mini_ff ? VGRA_MINI_PTR : 8'h00; // [R13] [R12]
        end
    end

    // Captures the read word in the setup phase; writes to the version
    // register and to read-only fields simply fall through.
    always_comb begin
        nxt_prdata = prdata_ff;
        if (i_psel && !i_penable) begin
            nxt_prdata = rd_word;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prdata_ff <= VGRA_WORD_RST;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign o_prdata  = prdata_ff;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit_ver && !hit_acc;

    // ****************************************************************
    // Sequencer.
    // ****************************************************************
    // Next state: load after reset, then address resets before reads.
    always_comb begin
        nxt_state   = state_ff;
        nxt_addr    = addr_ff;
        nxt_data    = data_ff;
        nxt_arst    = arst_ff;
        nxt_rstart  = rstart_ff;
        nxt_mini    = mini_ff;
        nxt_boot    = boot_ff;
        nxt_present = i_ee_present; // [R2]
        nxt_bib     = '0;
        case (state_ff)
            VGRA_ST_IDLE: begin
                if (boot_ff) begin
                    // The load begins without software when a part is present.
                    nxt_boot = 1'b0;
                    if (i_ee_present) begin
                        nxt_state = VGRA_ST_BOOT; // [R3]
                        nxt_addr  = VGRA_ADDR_RST;
                    end
                end else if (arst_ff) begin
                    // Address goes to zero; read data is left alone.
                    nxt_addr = VGRA_ADDR_RST; // [R7] [R8]
                    nxt_arst = 1'b0;          // [R7]
                end else if (rstart_ff) begin
                    if (present_ff) begin
                        nxt_state = VGRA_ST_READ; // [R9]
                    end else begin
                        // With no part there is nothing to wait for.
                        nxt_rstart = 1'b0;
                    end
                end
            end
            VGRA_ST_BOOT: begin
                if (i_ee_rsp.ack) begin
                    nxt_bib.valid = 1'b1;
                    nxt_bib.index = addr_ff;
                    nxt_bib.data  = i_ee_rsp.data;
                    if (addr_ff == VGRA_MINI_OFS) begin
                        nxt_mini = i_ee_rsp.data[VGRA_MINI_BIT]; // [R13]
                    end
                    if (addr_ff == BIB_BYTES - 8'h01) begin
                        nxt_addr  = VGRA_ADDR_RST;
                        nxt_state = VGRA_ST_IDLE;
                    end else begin
                        nxt_addr = addr_ff + 8'h01;
                    end
                end
            end
            VGRA_ST_READ: begin
                if (i_ee_rsp.ack) begin
                    nxt_data   = i_ee_rsp.data;   // [R11]
                    nxt_addr   = addr_ff + 8'h01;
                    nxt_rstart = 1'b0;            // [R10]
                    nxt_state  = VGRA_ST_IDLE;
                end
            end
            default: begin
                nxt_state = VGRA_ST_IDLE;
            end
        endcase
        // A software set in the clearing cycle wins over the clear.
        if (set_arst) begin
            nxt_arst = 1'b1; // [R7]
        end
        if (set_rstart) begin
            nxt_rstart = 1'b1; // [R9]
        end
    end

    // Registers the sequencer state.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff   <= VGRA_ST_IDLE;
            addr_ff    <= VGRA_ADDR_RST;
            data_ff    <= VGRA_DATA_RST;
            arst_ff    <= 1'b0;
            rstart_ff  <= 1'b0;
            mini_ff    <= 1'b0;
            present_ff <= 1'b0;
            boot_ff    <= 1'b1;
            bib_ff     <= '0;
        end else begin
            state_ff   <= nxt_state;
            addr_ff    <= nxt_addr;
            data_ff    <= nxt_data;
            arst_ff    <= nxt_arst;
            rstart_ff  <= nxt_rstart;
            mini_ff    <= nxt_mini;
            present_ff <= nxt_present;
            boot_ff    <= nxt_boot;
            bib_ff     <= nxt_bib;
        end
    end

    assign o_ee_req    = (state_ff == VGRA_ST_BOOT) || (state_ff == VGRA_ST_READ);
    assign o_ee_addr   = addr_ff;
    assign o_bib       = bib_ff;
    assign o_boot_done = !boot_ff && (state_ff != VGRA_ST_BOOT);

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    logic rd_ver; // Read access phase of the version register.
    logic rd_acc; // Read access phase of the access register.
    assign rd_ver = i_psel && i_penable && !i_pwrite && hit_ver;
    assign rd_acc = i_psel && i_penable && !i_pwrite && hit_acc;

    property p_ver_const;
        rd_ver |-> (o_prdata[31:25] == 7'h00) && (o_prdata[23:16] == 8'h01)
                   && (o_prdata[15:8] == 8'h00) && (o_prdata[7:0] == 8'h10);
    endproperty
    a_ver_const: assert property (p_ver_const) // [R1] [R4] [R5]
        else $error("Version constant fields wrong.");

    property p_present;
        rd_ver |-> (o_prdata[24] == $past(present_ff));
    endproperty
    a_present: assert property (p_present) // [R2]
        else $error("Presence bit does not follow detection.");

    property p_boot;
        (state_ff == VGRA_ST_IDLE) && boot_ff && i_ee_present
            |=> (state_ff == VGRA_ST_BOOT) && o_ee_req && (o_ee_addr == 8'h00);
    endproperty
    a_boot: assert property (p_boot) // [R3]
        else $error("Load did not start after reset.");

    property p_arst;
        (state_ff == VGRA_ST_IDLE) && !boot_ff && arst_ff && !set_arst
            |=> (addr_ff == 8'h00) && !arst_ff && $stable(data_ff);
    endproperty
    a_arst: assert property (p_arst) // [R7] [R8]
        else $error("Address reset misbehaved.");

    property p_read_go;
        (state_ff == VGRA_ST_IDLE) && !boot_ff && !arst_ff && rstart_ff && present_ff
            |=> o_ee_req && (state_ff == VGRA_ST_READ) && $stable(addr_ff);
    endproperty
    a_read_go: assert property (p_read_go) // [R9]
        else $error("Read did not start.");

    property p_read_done;
        (state_ff == VGRA_ST_READ) && i_ee_rsp.ack && !set_rstart
            |=> !rstart_ff && (data_ff == $past(i_ee_rsp.data))
                && (addr_ff == $past(addr_ff) + 8'h01);
    endproperty
    a_read_done: assert property (p_read_done) // [R10] [R11]
        else $error("Read completion wrong.");

    property p_acc_resv;
        rd_acc |-> (o_prdata[30:26] == 5'h00) && !o_prdata[24] && (o_prdata[15:8] == 8'h00);
    endproperty
    a_acc_resv: assert property (p_acc_resv) // [R12]
        else $error("Access reserved bits not zero.");

    property p_mini;
        rd_acc |-> (o_prdata[7:0] == ($past(mini_ff) ? 8'h20 : 8'h00));
    endproperty
    a_mini: assert property (p_mini) // [R13]
        else $error("Mini-ROM pointer wrong.");

    property p_zero_write;
        (state_ff == VGRA_ST_READ) && !i_ee_rsp.ack && wr_acc
            && !i_pwdata[VGRA_BIT_RSTART] |=> rstart_ff;
    endproperty
    a_zero_write: assert property (p_zero_write) // [R15]
        else $error("Zero write cancelled a read.");

    c_boot_done: cover property ((state_ff == VGRA_ST_BOOT) ##1 (state_ff == VGRA_ST_IDLE));
    c_sw_read: cover property ((state_ff == VGRA_ST_READ) && i_ee_rsp.ack);
    c_arst: cover property (arst_ff ##1 !arst_ff);
endmodule : vgra_core

// [sim/vgra_ee_model.sv]
// Model of the serial EEPROM byte engine that answers the block's byte port.
// Assumes the block's clock and reset; the answer delay is set by the bench.
`timescale 1ns/1ns
module vgra_ee_model
    import vgra_pkg::*;
(
    input  wire logic         i_mclk,   // Block clock.
    input  wire logic         i_resetn, // Asynchronous reset, active low.
    input  wire logic         i_req,    // A byte is wanted.
    input  wire logic [7:0]   i_addr,   // Byte address.
    input  wire logic [3:0]   i_wait,   // Cycles before the answer, at least one.
    output vgra_ee_rsp_t      o_rsp     // Answer pulse with the byte.
);
    // ****************************************************************
    // Contents and answer timing.
    // ****************************************************************
    logic [3:0] cnt_ff; // Cycles the current request has waited.

    // Fixed contents; byte six carries the mini-ROM flag in bit 5.
    function automatic logic [7:0] ee_byte(input logic [7:0] a);
        return (a == 8'h06) ? 8'h2C : (a ^ 8'hA5);
    endfunction : ee_byte

    // Answers after the wait; between answers the data toggles every cycle, so a stale byte matches only on every second cycle.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_ff <= 4'h0;
            o_rsp  <= '0;
        end else if (i_req && !o_rsp.ack && cnt_ff >= i_wait) begin
            cnt_ff <= 4'h0;
            o_rsp  <= {1'b1, ee_byte(i_addr)};
        end else begin
            cnt_ff     <= (i_req && !o_rsp.ack) ? cnt_ff + 4'h1 : 4'h0;
            o_rsp.ack  <= 1'b0;
            o_rsp.data <= ~o_rsp.data;
        end
    end
endmodule : vgra_ee_model

// [sim/version_and_eeprom_byte_access_access_test.sv]
// Self-checking bench for the version and EEPROM byte access registers.
// Assumes the core and the EEPROM engine model; APB master tasks drive it.
`timescale 1ns/1ns
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; $display("unexpected at %0t: got %h expected %h", $time, g, x); end end
module version_and_eeprom_byte_access_access_test
    import vgra_pkg::*;
;
    // ****************************************************************
    // Signals and instances.
    // ****************************************************************
    logic         mclk, resetn, psel, penable, pwrite, pready, pslverr; // Bus and clocking.
    logic [11:0]  paddr;      // Byte address.
    logic [31:0]  pwdata, prdata, q; // Write data, read data, last read.
    logic [3:0]   pstrb, ee_wait;    // Strobes and model delay.
    logic         e, ee_present, ee_req, boot_done; // Error, presence, request, load done.
    logic [7:0]   ee_addr;    // EEPROM byte address.
    vgra_ee_rsp_t ee_rsp;     // Engine answer.
    vgra_bib_t    bib;        // Loaded bytes.
    int           n_errors, checks_done, bib_n; // Counters.

    vgra_core #(.BIB_BYTES(8'h08)) i_vgra_core (.i_mclk(mclk), .i_resetn(resetn),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_ee_present(ee_present), .o_ee_req(ee_req),
        .o_ee_addr(ee_addr), .i_ee_rsp(ee_rsp), .o_bib(bib), .o_boot_done(boot_done));
    vgra_ee_model i_vgra_ee_model (.i_mclk(mclk), .i_resetn(resetn), .i_req(ee_req),
        .i_addr(ee_addr), .i_wait(ee_wait), .o_rsp(ee_rsp));

    // Clock of 10 ns.
    always #5 mclk = ~mclk;

    // Every loaded byte must match the EEPROM contents.
    always @(posedge mclk) begin
        if (bib.valid === 1'b1) begin
            `CHK(bib.data, i_vgra_ee_model.ee_byte(bib.index))
            bib_n++;
        end
    end

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads the access register until bit b has cleared.
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, VGRA_OFS_ACCESS, 32'h0, 4'h0);
            n++;
        end while (q[b] !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_errors++;
            wrap_up();
        end
    endtask : poll

    // Resets for three cycles and waits for the after-reset load.
    task automatic do_reset(input logic p);
        int n;
        resetn     <= 1'b0;
        ee_present <= p;
        repeat (3) @(posedge mclk);
        bib_n = 0;
        resetn <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (boot_done !== 1'b1 && n < 200);
        if (n >= 200) begin
            n_errors++;
            wrap_up();
        end
        // One more edge lets the load checker count the last byte before anyone reads the count.
        @(posedge mclk);
    endtask : do_reset

    // Expected access word after a finished read.
    function automatic logic [31:0] acc(input logic [7:0] k);
        return {8'h00, i_vgra_ee_model.ee_byte(k), 8'h00, VGRA_MINI_PTR};
    endfunction : acc

    // Prints counts and verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        {mclk, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {n_errors, checks_done, bib_n} = '0;
        resetn     = 1'b0;
        ee_present = 1'b1;
        ee_wait    = 4'h1;
        do_reset(1'b1);
        `CHK(bib_n, 8)
        apb(1'b0, VGRA_OFS_VERSION, 32'h0, 4'h0);
        `CHK(q, 32'h0101_0010)
        apb(1'b1, VGRA_OFS_VERSION, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, VGRA_OFS_VERSION, 32'h0, 4'h0);
        `CHK(q, 32'h0101_0010)
        apb(1'b0, VGRA_OFS_ACCESS, 32'h0, 4'h0);
        `CHK(q & 32'hFF00_FFFF, 32'h0000_0020)
        $display("test boot and version done");
        // Reads at prompt and slow engine speed; one write sets reserved bits too.
        for (int k = 0; k < 4; k++) begin
            ee_wait <= k[0] ? 4'h6 : 4'h1;
            apb(1'b1, VGRA_OFS_ACCESS, (k == 2) ? 32'h7FFF_FFFF : 32'h0200_0000, 4'hF);
            poll(VGRA_BIT_RSTART);
            `CHK(q, acc(k[7:0]))
        end
        ee_wait <= 4'h6;
        apb(1'b1, VGRA_OFS_ACCESS, 32'h0200_0000, 4'hF);
        apb(1'b1, VGRA_OFS_ACCESS, 32'h0000_0000, 4'hF);
        poll(VGRA_BIT_RSTART);
        `CHK(q, acc(8'h04))
        apb(1'b1, VGRA_OFS_ACCESS, 32'h8000_0000, 4'hF);
        poll(VGRA_BIT_ARST);
        `CHK(q, acc(8'h04))
        apb(1'b1, VGRA_OFS_ACCESS, 32'h0200_0000, 4'hF);
        poll(VGRA_BIT_RSTART);
        `CHK(q, acc(8'h00))
        // Address reset and read start in one write: the reset is served first.
        apb(1'b1, VGRA_OFS_ACCESS, 32'h8200_0000, 4'hF);
        poll(VGRA_BIT_RSTART);
        `CHK(q, acc(8'h00))
        $display("test byte reads done");
        apb(1'b1, VGRA_OFS_ACCESS, 32'h0200_0000, 4'h7);
        apb(1'b0, VGRA_OFS_ACCESS, 32'h0, 4'h0);
        `CHK(q, acc(8'h00))
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        $display("test refused accesses done");
        do_reset(1'b0);
        `CHK(bib_n, 0)
        apb(1'b0, VGRA_OFS_VERSION, 32'h0, 4'h0);
        `CHK(q, 32'h0001_0010)
        apb(1'b1, VGRA_OFS_ACCESS, 32'h0200_0000, 4'hF);
        poll(VGRA_BIT_RSTART);
        `CHK(q, {8'h00, VGRA_DATA_RST, 16'h0000})
        $display("test absent eeprom done");
        wrap_up();
    end
endmodule : version_and_eeprom_byte_access_access_test
